// [fdc_cfg_bank.sv]
// Floppy logical device configuration register bank
`timescale 1ns/1ps
`default_nettype none
module fdc_cfg_bank (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_index,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic drive0_select_n,
  input wire logic drive1_select_n,
  input wire logic par_drive0_select_n,
  input wire logic par_drive1_select_n,
  input wire logic par_route,
  input wire logic write_protect_in_n,
  input wire logic floppy_wp_disable,
  input wire logic dens_core,
  output logic write_protect_core,
  output logic enhanced_mode,
  output logic dma_non_burst,
  output logic [1:0] interface_mode,
  output logic push_pull_driver,
  output logic pin_tristate,
  output logic par_push_pull,
  output logic par_tristate,
  output logic density_out,
  output logic [1:0] drive0_type,
  output logic [1:0] drive1_type,
  output logic [1:0] drive0_type_select,
  output logic [1:0] drive1_type_select,
  output logic [1:0] drive0_rate_table_select,
  output logic [1:0] drive1_rate_table_select,
  output logic drive0_precomp_disable,
  output logic drive1_precomp_disable
);
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] opt;
    logic [7:0] dtype;
    logic [7:0] drv0;
    logic [7:0] drv1;
    logic [7:0] rdata;
    logic [1:0] wp_s1;
    logic [1:0] wp_s2;
    logic [1:0] ds_s1;
    logic [1:0] ds_s2;
    logic [1:0] pds_s1;
    logic [1:0] pds_s2;
    logic par_s1;
    logic par_s2;
    logic dens_s1;
    logic dens_s2;
    logic wp_out;
    logic dens_out;
  } fdc_state_s;

  fdc_state_s st_q;
  fdc_state_s st_d;
  logic wp_comb;
  logic dens_comb;
  logic sel0;
  logic sel1;

  // Read mux for the bank; unmapped and reserved indices return zero
  function automatic logic [7:0] fcb_read(input fdc_state_s s,
                                          input logic [7:0] idx);
    unique case (idx)
      fdc_cfg_pkg::MODE_IDX: fcb_read = s.mode;
      fdc_cfg_pkg::OPT_IDX: fcb_read = s.opt;
      fdc_cfg_pkg::TYPE_IDX: fcb_read = s.dtype;
      fdc_cfg_pkg::RSVD_IDX: fcb_read = 8'h00;
      fdc_cfg_pkg::DRV0_IDX: fcb_read = s.drv0;
      fdc_cfg_pkg::DRV1_IDX: fcb_read = s.drv1;
      default: fcb_read = 8'h00;
    endcase
  endfunction

  // One drive select, from the dedicated pin or the parallel port route
  function automatic logic fdc_pick_sel(input logic route,
                                        input logic ded_n,
                                        input logic par_n);
    fdc_pick_sel = route ? ~par_n : ~ded_n;
  endfunction

  // Drive select either from dedicated pins or parallel port route
  assign sel0 = fdc_pick_sel(st_q.par_s2, st_q.ds_s2[0], st_q.pds_s2[0]);
  assign sel1 = fdc_pick_sel(st_q.par_s2, st_q.ds_s2[1], st_q.pds_s2[1]);

  fdc_wp_dens u_wp_dens (
    .force_wp(st_q.opt[fdc_cfg_pkg::OPT_FWP_BIT]),
    .drive0_sel(sel0),
    .drive1_sel(sel1),
    .wp_pin(~st_q.wp_s2[0]),
    .wp_disable(st_q.wp_s2[1]),
    .dens_mode(st_q.opt[fdc_cfg_pkg::OPT_DENS_LSB +: 2]),
    .dens_core(st_q.dens_s2),
    .wp_core(wp_comb),
    .dens_out(dens_comb)
  );

  // Next state: synchronisers, register writes, read data
  always_comb begin
    st_d = st_q;
    st_d.wp_s1 = {floppy_wp_disable, write_protect_in_n};
    st_d.wp_s2 = st_q.wp_s1;
    st_d.ds_s1 = {drive1_select_n, drive0_select_n};
    st_d.ds_s2 = st_q.ds_s1;
    st_d.pds_s1 = {par_drive1_select_n, par_drive0_select_n};
    st_d.pds_s2 = st_q.pds_s1;
    st_d.par_s1 = par_route;
    st_d.par_s2 = st_q.par_s1;
    st_d.dens_s1 = dens_core;
    st_d.dens_s2 = st_q.dens_s1;
    st_d.wp_out = wp_comb;
    st_d.dens_out = dens_comb;
    if (cfg_wr) begin
      unique case (cfg_index)
        fdc_cfg_pkg::MODE_IDX: st_d.mode = cfg_wdata;
        fdc_cfg_pkg::OPT_IDX: st_d.opt = cfg_wdata;
        fdc_cfg_pkg::TYPE_IDX: st_d.dtype = cfg_wdata;
        fdc_cfg_pkg::DRV0_IDX:
          st_d.drv0 = cfg_wdata & fdc_cfg_pkg::DRV_WMASK;
        fdc_cfg_pkg::DRV1_IDX:
          st_d.drv1 = cfg_wdata & fdc_cfg_pkg::DRV_WMASK;
        default: st_d.rdata = st_d.rdata; // Reserved and unmapped ignored
      endcase
    end
    if (cfg_rd) begin
      st_d.rdata = fcb_read(st_q, cfg_index);
    end
  end

  // State register; only hard reset reaches rst_b, soft reset is not wired
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
      st_q.mode <= fdc_cfg_pkg::MODE_RST;
      st_q.opt <= fdc_cfg_pkg::OPT_RST;
      st_q.dtype <= fdc_cfg_pkg::TYPE_RST;
      st_q.drv0 <= fdc_cfg_pkg::DRV_RST;
      st_q.drv1 <= fdc_cfg_pkg::DRV_RST;
      st_q.wp_s1 <= 2'h1;
      st_q.wp_s2 <= 2'h1;
      st_q.ds_s1 <= 2'h3;
      st_q.ds_s2 <= 2'h3;
      st_q.pds_s1 <= 2'h3;
      st_q.pds_s2 <= 2'h3;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // Decoded fields straight from flip-flops
  assign cfg_rdata = st_q.rdata;
  assign write_protect_core = st_q.wp_out;
  assign density_out = st_q.dens_out;
  assign enhanced_mode = st_q.mode[fdc_cfg_pkg::MODE_ENH_BIT];
  assign dma_non_burst = st_q.mode[fdc_cfg_pkg::MODE_NOBURST_BIT];
  assign interface_mode = st_q.mode[fdc_cfg_pkg::MODE_IF_LSB +: 2];
  assign push_pull_driver = st_q.mode[fdc_cfg_pkg::MODE_PUSHPULL_BIT];
  assign pin_tristate = st_q.mode[fdc_cfg_pkg::MODE_TRISTATE_BIT];
  // Parallel-port floppy pins keep open drain and stay driven
  assign par_push_pull = st_q.par_s2 & 1'b0;
  assign par_tristate = st_q.par_s2 & 1'b0;
  assign drive0_type = st_q.dtype[1:0];
  assign drive1_type = st_q.dtype[3:2];
  assign drive0_type_select = st_q.drv0[fdc_cfg_pkg::DRV_TYPE_LSB +: 2];
  assign drive1_type_select = st_q.drv1[fdc_cfg_pkg::DRV_TYPE_LSB +: 2];
  assign drive0_rate_table_select = st_q.drv0[fdc_cfg_pkg::DRV_RATE_LSB +: 2];
  assign drive1_rate_table_select = st_q.drv1[fdc_cfg_pkg::DRV_RATE_LSB +: 2];
  assign drive0_precomp_disable =
    st_q.drv0[fdc_cfg_pkg::DRV_NOPRECOMP_BIT];
  assign drive1_precomp_disable =
    st_q.drv1[fdc_cfg_pkg::DRV_NOPRECOMP_BIT];
endmodule
`default_nettype wire

// [fdc_cfg_chk.sv]
// Assertion checker for the floppy config bank ports
`timescale 1ns/1ps
`default_nettype none
module fdc_cfg_chk (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_index,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic enhanced_mode,
  input wire logic dma_non_burst,
  input wire logic [1:0] interface_mode,
  input wire logic push_pull_driver,
  input wire logic pin_tristate,
  input wire logic par_push_pull,
  input wire logic par_tristate,
  input wire logic [1:0] drive0_type,
  input wire logic [1:0] drive1_type,
  input wire logic [1:0] drive0_type_select,
  input wire logic [1:0] drive1_type_select,
  input wire logic [1:0] drive0_rate_table_select,
  input wire logic [1:0] drive1_rate_table_select,
  input wire logic drive0_precomp_disable,
  input wire logic drive1_precomp_disable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Accepted accesses to one index
  sequence s_wr(logic [7:0] ix);
    clk_en && cfg_wr && cfg_index == ix;
  endsequence
  sequence s_rd(logic [7:0] ix);
    clk_en && cfg_rd && cfg_index == ix;
  endsequence
  // Reset defaults; field outputs follow the write one clock later; parallel pins stay off; reserved reads zero
  rst_dflt_a: assert property ($rose(rst_b) |->
    dma_non_burst && !enhanced_mode && interface_mode == 2'h3 &&
    drive1_type == 2'h3) else $error("bad default");
  mode_low_a: assert property (s_wr(fdc_cfg_pkg::MODE_IDX) |=>
    {dma_non_burst, enhanced_mode} == $past(cfg_wdata[1:0]))
    else $error("mode");
  if_mode_a: assert property (s_wr(fdc_cfg_pkg::MODE_IDX) |=>
    interface_mode == $past(cfg_wdata[3:2])) else $error("interface mode");
  pin_ctrl_a: assert property (s_wr(fdc_cfg_pkg::MODE_IDX) |=>
    {pin_tristate, push_pull_driver} == $past(cfg_wdata[7:6]))
    else $error("pins");
  par_pins_a: assert property (!par_push_pull && !par_tristate)
    else $error("parallel pins touched");
  type_split_a: assert property (s_wr(fdc_cfg_pkg::TYPE_IDX) |=>
    {drive1_type, drive0_type} == $past(cfg_wdata[3:0])) else $error("type");
  drv0_fld_a: assert property (s_wr(fdc_cfg_pkg::DRV0_IDX) |=>
    {drive0_precomp_disable, drive0_rate_table_select, drive0_type_select}
    == $past({cfg_wdata[6], cfg_wdata[4:3], cfg_wdata[1:0]}))
    else $error("d0");
  drv1_fld_a: assert property (s_wr(fdc_cfg_pkg::DRV1_IDX) |=>
    {drive1_precomp_disable, drive1_rate_table_select, drive1_type_select}
    == $past({cfg_wdata[6], cfg_wdata[4:3], cfg_wdata[1:0]}))
    else $error("d1");
  rsvd_zero_a: assert property (s_rd(fdc_cfg_pkg::RSVD_IDX) |=>
    cfg_rdata == 8'h00) else $error("reserved index not zero");
endmodule
// Attach to the bank top
bind fdc_cfg_bank fdc_cfg_chk i_chk (.sys_clk(sys_clk), .rst_b(rst_b),
  .clk_en(clk_en), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_index(cfg_index),
  .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .enhanced_mode(enhanced_mode),
  .dma_non_burst(dma_non_burst), .interface_mode(interface_mode),
  .push_pull_driver(push_pull_driver), .pin_tristate(pin_tristate),
  .par_push_pull(par_push_pull), .par_tristate(par_tristate),
  .drive0_type(drive0_type), .drive1_type(drive1_type),
  .drive0_type_select(drive0_type_select),
  .drive1_type_select(drive1_type_select),
  .drive0_rate_table_select(drive0_rate_table_select),
  .drive1_rate_table_select(drive1_rate_table_select),
  .drive0_precomp_disable(drive0_precomp_disable),
  .drive1_precomp_disable(drive1_precomp_disable));
`default_nettype wire

// [fdc_cfg_pkg.sv]
// Package with register map, field positions and reset values of the floppy config bank
package fdc_cfg_pkg;
  localparam logic [7:0] MODE_IDX = 8'hF0;
  localparam logic [7:0] OPT_IDX = 8'hF1;
  localparam logic [7:0] TYPE_IDX = 8'hF2;
  localparam logic [7:0] RSVD_IDX = 8'hF3;
  localparam logic [7:0] DRV0_IDX = 8'hF4;
  localparam logic [7:0] DRV1_IDX = 8'hF5;
  localparam logic [7:0] MODE_RST = 8'h0E;
  localparam logic [7:0] OPT_RST = 8'h00;
  localparam logic [7:0] TYPE_RST = 8'hFF;
  localparam logic [7:0] DRV_RST = 8'h00;
  localparam logic [7:0] DRV_WMASK = 8'h5B;
  localparam int MODE_ENH_BIT = 0;
  localparam int MODE_NOBURST_BIT = 1;
  localparam int MODE_IF_LSB = 2;
  localparam int MODE_PUSHPULL_BIT = 6;
  localparam int MODE_TRISTATE_BIT = 7;
  localparam int OPT_FWP_BIT = 0;
  localparam int OPT_DENS_LSB = 2;
  localparam int DRV_TYPE_LSB = 0;
  localparam int DRV_RATE_LSB = 3;
  localparam int DRV_NOPRECOMP_BIT = 6;
  localparam logic [1:0] DENS_FORCE_ONE = 2'h2;
  localparam logic [1:0] DENS_FORCE_ZERO = 2'h3;
endpackage

// [fdc_wp_dens.sv]
// Write protect combiner and density override for the floppy core
`timescale 1ns/1ps
`default_nettype none
module fdc_wp_dens (
  input wire logic force_wp,
  input wire logic drive0_sel,
  input wire logic drive1_sel,
  input wire logic wp_pin,
  input wire logic wp_disable,
  input wire logic [1:0] dens_mode,
  input wire logic dens_core,
  output logic wp_core,
  output logic dens_out
);
  // Write protect seen by core, also registered out as write_protect_core
  assign wp_core = (drive0_sel & force_wp) | (drive1_sel & force_wp) |
                   wp_pin | wp_disable;
  // Density override
  always_comb begin
    unique case (dens_mode)
      fdc_cfg_pkg::DENS_FORCE_ONE: dens_out = 1'b1;
      fdc_cfg_pkg::DENS_FORCE_ZERO: dens_out = 1'b0;
      default: dens_out = dens_core;
    endcase
  end
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the floppy config bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk, rst_b, clk_en, cfg_wr, cfg_rd, wp_dis, dens_core, wp_core;
  logic d0_n, d1_n, pd0_n, pd1_n, par_route, wp_n, dens, pp, tri_st;
  logic [7:0] cfg_index, cfg_wdata, cfg_rdata;
  logic [1:0] ifm, t0, t1, ts0, ts1, rt0, rt1;
  logic enh, nburst, par_pp, par_ts, pc0, pc1;
  int bad_count = 0;
  int check_count = 0;
  fdc_cfg_bank i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_index(cfg_index),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .drive0_select_n(d0_n),
    .drive1_select_n(d1_n), .par_drive0_select_n(pd0_n),
    .par_drive1_select_n(pd1_n), .par_route(par_route),
    .write_protect_in_n(wp_n), .floppy_wp_disable(wp_dis),
    .dens_core(dens_core), .write_protect_core(wp_core), .enhanced_mode(enh),
    .dma_non_burst(nburst), .interface_mode(ifm), .push_pull_driver(pp),
    .pin_tristate(tri_st), .par_push_pull(par_pp), .par_tristate(par_ts),
    .density_out(dens), .drive0_type(t0), .drive1_type(t1),
    .drive0_type_select(ts0), .drive1_type_select(ts1),
    .drive0_rate_table_select(rt0), .drive1_rate_table_select(rt1),
    .drive0_precomp_disable(pc0), .drive1_precomp_disable(pc1));
  // Compare, count and report
  task automatic chk(input string n, input logic [7:0] s, e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] i, d);
    @(negedge sys_clk);
    cfg_wr = 1'b1;
    cfg_index = i;
    cfg_wdata = d;
    @(negedge sys_clk);
    cfg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] i, e);
    @(negedge sys_clk);
    cfg_rd = 1'b1;
    cfg_index = i;
    @(negedge sys_clk);
    cfg_rd = 1'b0;
    chk("rdata", cfg_rdata, e);
  endtask
  // Set pins {par_route,d0,d1,pd0,wp,dis}, let sync settle, check protect
  task automatic pins(input logic [5:0] v, input logic e);
    {par_route, d0_n, d1_n, pd0_n, wp_n, wp_dis} = v;
    repeat (5) @(negedge sys_clk);
    chk("write_protect", wp_core, e);
  endtask
  task automatic dflts;
    logic [7:0] d [6];
    d = '{8'h0E, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) begin
      rd(8'(8'hF0 + i), d[i]);
    end
  endtask
  task automatic wrap_up;
    if (bad_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Watchdog well past the expected run
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end
  initial begin
    {rst_b, cfg_wr, cfg_rd, wp_dis, dens_core, par_route} = '0;
    {clk_en, d0_n, d1_n, pd0_n, pd1_n, wp_n} = '1;
    cfg_index = 8'h00;
    cfg_wdata = 8'h00;
    repeat (2) @(negedge sys_clk);
    rst_b = 1'b1;
    dflts();
    for (int c = 0; c < 4; c++) begin
      wr(8'hF0, {c[0], c[1], 2'h0, c[1:0], c[0], c[1]});
      rd(8'hF0, {c[0], c[1], 2'h0, c[1:0], c[0], c[1]});
      chk("if_mode", ifm, c[1:0]);
      chk("drivers", {tri_st, pp}, {c[0], c[1]});
      chk("mode_low", {nburst, enh}, {c[0], c[1]});
    end
    clk_en = 1'b0;
    wr(8'hF0, 8'h0E);
    clk_en = 1'b1;
    rd(8'hF0, 8'hCF);
    for (int k = 0; k < 8; k++) begin
      dens_core = k[2];
      wr(8'hF1, {4'h0, k[1:0], 2'h0});
      repeat (4) @(negedge sys_clk);
      chk("density", dens, k[1] ? !k[0] : k[2]);
    end
    wr(8'hF1, 8'h01);
    pins(6'b001110, 1'b1);
    pins(6'b010110, 1'b1);
    pins(6'b011110, 1'b0);
    pins(6'b111010, 1'b1);
    pins(6'b101110, 1'b0);
    wr(8'hF1, 8'h00);
    chk("par_pins", {par_pp, par_ts}, 8'h00);
    pins(6'b001110, 1'b0);
    pins(6'b011100, 1'b1);
    pins(6'b011111, 1'b1);
    wr(8'hF2, 8'h9B);
    rd(8'hF2, 8'h9B);
    chk("types", {t1, t0}, 8'h0B);
    wr(8'hF3, 8'hFF);
    rd(8'hF3, 8'h00);
    wr(8'hF4, 8'hFF);
    rd(8'hF4, 8'h5B);
    chk("drive0", {pc0, rt0, ts0}, 8'h1F);
    wr(8'hF5, 8'hE5);
    rd(8'hF5, 8'h41);
    chk("drive1", {pc1, rt1, ts1}, 8'h11);
    @(negedge sys_clk);
    rst_b = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_b = 1'b1;
    dflts();
    wrap_up();
  end
endmodule
`default_nettype wire
